/* File: dv/test_bit_clear_field_complement_unit.sv */
`timescale 1ns/1ps
`include "bit_unit_params.svh"
module test_bit_clear_field_complement_unit;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_req, mem_we, mem_ack, mem_stall;
  logic [31:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] mem [256]; // Byte memory seen through the design's memory port.
  int n_mismatch, tests_run, cycles;
  bit_clear_field_complement_unit bit_clear_field_complement_unit_i (.core_clk(core_clk),
    .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // The clock toggles every 10 ns, a period of 20 ns.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Memory answers one byte every other cycle unless stalled; idle read data keeps changing.
  always @(posedge core_clk) begin
    if (mem_req && !mem_ack && !mem_stall) begin
      mem_ack <= 1'b1;
      if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
  // A hang is cut short after a cycle ceiling well above the expected run.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: response %b, expected %b", $time, got, exp);
    end
  endtask
  // Offers address and data together and releases each channel once it is taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit fin;
    fin = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // The response is accepted a cycle after it shows, so it must stand meanwhile.
    while (!fin) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        fin = 1;
      end else if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b1;
      end
    end
  endtask
  // Holds the read request until taken and rready until the answer is sampled.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit fin;
    fin = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!fin) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        fin = 1;
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_resp(r, `RESP_OK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk_resp(r, `RESP_OK);
    chk_word(d, exp);
  endtask
  function automatic logic [7:0] da(input int i);
    return {`OFS_DREG_HI, i[2:0], 2'b00};
  endfunction
  // Polls status until done and compares the final status word.
  task automatic wait_op(input logic [31:0] st);
    logic [31:0] d;
    logic [1:0] r;
    do axi_read(`OFS_STATUS, d, r); while (d[0] !== 1'b1);
    chk_word(d, st);
  endtask
  task automatic run_op(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] st);
    wr(`OFS_CMD, {ext, op});
    wait_op(st);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, an unmapped place and the read-only status word.
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    rd(`OFS_CCR, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    rd(da(7), 32'h0);
    axi_read(8'h40, d, r);
    chk_resp(r, `RESP_ERR);
    chk_word(d, 32'h0);
    axi_write(8'h44, 32'h1, r);
    chk_resp(r, `RESP_ERR);
    wr(`OFS_STATUS, 32'hffffffff);
    rd(`OFS_STATUS, 32'h0);
  endtask
  // Register clears: bit numbers beyond 31 wrap, only Z moves.
  task automatic t_reg_clear();
    wr(da(1), 32'd63);
    wr(da(0), 32'h80000001);
    wr(`OFS_CCR, 32'h1f);
    run_op(16'h0380, 16'h0000, 32'h1);
    rd(da(0), 32'h00000001);
    rd(`OFS_CCR, 32'h1b);
    wr(da(2), 32'h2);
    wr(`OFS_CCR, 32'h0);
    run_op(16'h0882, 16'h0020, 32'h1);
    rd(da(2), 32'h2);
    rd(`OFS_CCR, 32'h04);
  endtask
  // Memory clears through every allowed mode, one byte only.
  task automatic t_mem_clear();
    logic [5:0] ea [7] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38, 6'h39};
    mem[8'h20] = 8'hff;
    mem[8'h21] = 8'h5a;
    wr(`OFS_EA, 32'h20);
    for (int k = 0; k < 7; k++) begin
      wr(`OFS_CCR, 32'h04);
      run_op(16'h0880 | {10'h0, ea[k]}, 16'(k + 8), 32'h1);
      rd(`OFS_CCR, 32'h0);
      chk_word({24'h0, mem[8'h20]}, {24'h0, 8'hff << (k + 1)});
    end
    chk_word({24'h0, mem[8'h21]}, 32'h5a);
  endtask
  // Register writes are refused while a stalled memory operation is pending.
  task automatic t_busy();
    logic [1:0] r;
    mem[8'h30] = 8'h81;
    wr(`OFS_EA, 32'h30);
    wr(`OFS_CCR, 32'h04);
    mem_stall <= 1'b1;
    wr(`OFS_CMD, {16'h000f, 16'h0890});
    axi_write(`OFS_CCR, 32'h1f, r);
    chk_resp(r, `RESP_ERR);
    rd(`OFS_STATUS, 32'h4);
    mem_stall <= 1'b0;
    wait_op(32'h1);
    rd(`OFS_CCR, 32'h0);
    chk_word({24'h0, mem[8'h30]}, 32'h01);
  endtask
  // Field complements on data registers, immediate and register sourced.
  task automatic t_field_reg();
    wr(da(3), 32'hf0000000);
    wr(`OFS_CCR, 32'h13);
    run_op(16'heac3, 16'h0004, 32'h1);
    rd(da(3), 32'h0);
    rd(`OFS_CCR, 32'h18);
    wr(da(4), 32'hfffffffc);
    wr(da(5), 32'd40);
    wr(da(6), 32'h0);
    run_op(16'heac6, 16'h0925, 32'h1);
    rd(da(6), 32'hf000000f);
    rd(`OFS_CCR, 32'h14);
    wr(da(7), 32'h12345678);
    run_op(16'heac7, 16'h0000, 32'h1);
    rd(da(7), 32'hedcba987);
    rd(`OFS_CCR, 32'h10);
  endtask
  // Memory field across two bytes, then the same field by a negative register offset.
  task automatic t_field_mem();
    mem[8'h10] = 8'ha5;
    mem[8'h11] = 8'h3c;
    mem[8'h12] = 8'h77;
    wr(`OFS_EA, 32'h10);
    wr(`OFS_CCR, 32'h1f);
    run_op(16'head0, 16'h010c, 32'h1);
    rd(`OFS_CCR, 32'h10);
    chk_word({16'h0, mem[8'h10], mem[8'h11]}, 32'haac3);
    wr(da(4), 32'hfffffff4);
    wr(`OFS_EA, 32'h12);
    run_op(16'head0, 16'h090c, 32'h1);
    rd(`OFS_CCR, 32'h18);
    chk_word({8'h0, mem[8'h10], mem[8'h11], mem[8'h12]}, 32'ha53c77);
  endtask
  // Disallowed modes and reserved bits change nothing.
  task automatic t_illegal();
    logic [31:0] bad [10] = '{{16'h0, 16'h0388}, {16'h0001, 16'h08bc}, {16'h0, 16'h08ba},
      {16'h0, 16'head8}, {16'h0, 16'heae0}, {16'h0, 16'heac8}, {16'h0, 16'heafc},
      {16'h0e00, 16'heac0}, {16'h8018, 16'heac0}, {16'h0100, 16'h0880}};
    wr(da(0), 32'h55);
    wr(`OFS_CCR, 32'h0a);
    foreach (bad[i]) begin
      run_op(bad[i][15:0], bad[i][31:16], 32'h3);
      rd(da(0), 32'h55);
      rd(`OFS_CCR, 32'h0a);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    cycles = 0;
    n_mismatch = 0;
    tests_run = 0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mem_ack = 1'b0;
    mem_stall = 1'b0;
    mem_rdata = 8'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_bus();
    t_reg_clear();
    t_mem_clear();
    t_busy();
    t_field_reg();
    t_field_mem();
    t_illegal();
    report_and_stop();
  end
endmodule // test_bit_clear_field_complement_unit

/* File: logic/bit_clear_field_complement_unit.sv */
`timescale 1ns/1ps
`include "bit_unit_params.svh"
// What this block does
// - Test chosen bit into Z, then clear it.
// - Z set if bit was zero; others kept.
// - Register destination bit number modulo 32.
// - Memory: read byte, clear bit mod 8, write.
// - Bit zero is the least significant bit.
// - Bit number from immediate or data register.
// - Opcode field 11:9 picks the bit register.
// - Clear allows only data alterable modes.
// - Long on register, byte on memory.
// - Complement every field bit, write back.
// - Field flags come from original value.
// - N is field MSB, Z all zero, VC cleared.
// - Field given by start offset and width.
// - Offset register from bits 8:6, 10:9 zero.
// - Immediate offset ranges 0 to 31.
// - Register offset is signed 32 bits.
// - Width register from bits 2:0, 4:3 zero.
// - Immediate width zero means 32 bits.
// - Register width modulo 32, zero is 32.
// - Complement allows data_reg or alterable control modes.
module bit_clear_field_complement_unit
  import bit_unit_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------

  // Maps a byte address to the register it names.
  function automatic reg_sel_t reg_sel(input logic [7:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[7:5] == `OFS_DREG_HI && a[1:0] == 2'h0) begin
      s = SEL_DREG;
    end else if (a == `OFS_CMD) begin
      s = SEL_CMD;
    end else if (a == `OFS_STATUS) begin
      s = SEL_STATUS;
    end else if (a == `OFS_CCR) begin
      s = SEL_CCR;
    end else if (a == `OFS_EA) begin
      s = SEL_EA;
    end
    return s;
  endfunction

  // Applies byte strobes to a word.
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Tells whether an addressing mode suits the operation.
  function automatic logic ea_ok(input logic fld, input logic [2:0] m,
    input logic [2:0] r);
    logic ok;
    ok = 1'b0;
    unique case (m)
      `MODE_AREG: ok = 1'b0;
      `MODE_POSTINC, `MODE_PREDEC: ok = !fld;
      `MODE_EXT: ok = (r[2:1] == 2'h0);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // ----------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------

  unit_regs_t q; // Registered state.
  unit_regs_t n; // Next state.
  logic [2:0] mode; // Addressing mode field.
  logic [2:0] rg; // Addressing register field.
  logic dyn; // Register bit number clear.
  logic stat; // Immediate bit number clear.
  logic fld; // Field complement.
  logic clr; // Either clear form.
  logic ext_ok; // Extension word well formed.
  logic legal; // Instruction may run.
  logic regdst; // Destination is a data register.
  logic [31:0] dsel; // Destination register value.
  logic [31:0] bitnum; // Bit number operand.
  logic [31:0] bmask; // One-hot bit in a register.
  logic tested; // Selected register bit.
  logic [31:0] off; // Field offset.
  logic [4:0] wraw; // Raw width code.
  logic [5:0] wid; // Field width, 1 to 32.
  logic [31:0] top; // Left-aligned width mask.
  logic [63:0] rot64; // Rotated field mask pair.
  logic [31:0] rmask; // Field mask in a register.
  logic fmsb; // Field MSB in a register.
  logic [6:0] span; // Bit span for byte count.
  logic [2:0] nb; // Bytes that a memory field spans.
  logic [39:0] mmask; // Mask over the byte buffer.
  logic [31:0] maddr; // First memory byte address.
  reg_sel_t wsel; // Register written.
  reg_sel_t rsel; // Register read.

  assign mode = q.op[5:3];
  assign rg = q.op[2:0];
  // Opcode decode.
  assign dyn = (q.op[15:12] == `OP_DYN_TOP) && (q.op[8:6] == `OP_DYN_SEL);
  assign stat = (q.op[15:6] == `OP_STAT);
  assign fld = (q.op[15:6] == `OP_FLD);
  assign clr = dyn || stat;
  // Reserved extension bits must be zero.
  // The register bit number form carries no extension word, so nothing is checked.
  assign ext_ok = stat ? (q.ext[15:8] == 8'h00) :
    (!fld || ((q.ext[15:12] == 4'h0) &&
    (!q.ext[11] || q.ext[10:9] == 2'h0) &&
    (!q.ext[5] || q.ext[4:3] == 2'h0)));
  assign legal = (clr || fld) && ext_ok && ea_ok(fld, mode, rg);
  assign regdst = (mode == `MODE_DREG);
  assign dsel = q.dreg[rg];
  // The bit number comes from an opcode-named register or the extension.
  assign bitnum = dyn ? q.dreg[q.op[11:9]] : {24'h0, q.ext[7:0]};
  // Bit zero is the least significant; the number wraps at 32.
  assign bmask = 32'h1 << bitnum[4:0];
  assign tested = |(dsel & bmask);
  // Offset is a signed register value or an immediate.
  assign off = q.ext[11] ? q.dreg[q.ext[8:6]] : {27'h0, q.ext[10:6]};
  assign wraw = q.ext[5] ? q.dreg[q.ext[2:0]][4:0] : q.ext[4:0];
  assign wid = (wraw == 5'h0) ? `FIELD_MAX : {1'b0, wraw};
  assign top = ~(32'hffffffff >> wid);
  // A register field starts at bit 31 minus offset and wraps round.
  assign rot64 = {top, top} >> off[4:0];
  assign rmask = rot64[31:0];
  assign fmsb = dsel[5'h1f - off[4:0]];
  assign span = {4'h0, off[2:0]} + {1'b0, wid} + 7'h07;
  assign nb = span[5:3];
  // Memory fields count bits from the MSB of the first byte.
  assign mmask = clr ? {8'h01 << bitnum[2:0], 32'h0} :
    ({top, 8'h00} >> off[2:0]);
  assign maddr = clr ? q.ea : (q.ea + {{3{off[31]}}, off[31:3]});
  assign wsel = reg_sel(q.awaddr);
  assign rsel = reg_sel(s_axi_araddr);

  // ----------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------

  // Sequencer, datapath and bus slave in one pass.
  always_comb begin
    n = q;
    unique case (q.st)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        n.done = 1'b1;
        n.st = ST_IDLE;
        if (!legal) begin
          // Only the error and done flags change.
          n.illegal = 1'b1;
        end else if (regdst && clr) begin
          // Long operation on a data register.
          n.ccr[`CCR_Z] = !tested;
          n.dreg[rg] = dsel & ~bmask;
        end else if (regdst) begin
          // Flags from the value before inversion.
          n.ccr[`CCR_N] = fmsb;
          n.ccr[`CCR_Z] = !(|(dsel & rmask));
          n.ccr[`CCR_V] = 1'b0;
          n.ccr[`CCR_C] = 1'b0;
          n.dreg[rg] = dsel ^ rmask;
        end else begin
          // Memory read-modify-write.
          n.done = 1'b0;
          n.st = ST_READ;
          n.is_clr = clr;
          n.mask = mmask;
          n.nbytes = clr ? 3'h1 : nb;
          n.addr = maddr;
          n.cnt = 3'h0;
          n.mem_req = 1'b1;
          n.mem_we = 1'b0;
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          // Bytes fill the buffer from its top.
          n.bufv[6'h27 - {q.cnt, 3'h0} -: 8] = mem_rdata;
          n.cnt = q.cnt + 3'h1;
          n.addr = q.addr + 32'h1;
          if (n.cnt == q.nbytes) begin
            if (q.is_clr) begin
              n.ccr[`CCR_Z] = !(|(n.bufv & q.mask));
              n.bufv = n.bufv & ~q.mask;
            end else begin
              // Flags are taken before the inversion is applied.
              n.ccr[`CCR_N] = |(n.bufv & q.mask & ~(q.mask >> 1));
              n.ccr[`CCR_Z] = !(|(n.bufv & q.mask));
              n.ccr[`CCR_V] = 1'b0;
              n.ccr[`CCR_C] = 1'b0;
              n.bufv = n.bufv ^ q.mask;
            end
            n.st = ST_WRITE;
            n.cnt = 3'h0;
            n.addr = q.addr + 32'h1 - {29'h0, q.nbytes};
            n.mem_we = 1'b1;
            n.mem_wdata = n.bufv[39:32];
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          // Write the same bytes back in the same order.
          n.cnt = q.cnt + 3'h1;
          n.addr = q.addr + 32'h1;
          n.mem_wdata = q.bufv[6'h27 - {n.cnt, 3'h0} -: 8];
          if (n.cnt == q.nbytes) begin
            n.mem_req = 1'b0;
            n.mem_we = 1'b0;
            n.done = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
    endcase

    // Write address and data may arrive in either order.
    if (s_axi_awvalid && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Perform a write once both halves are held.
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OK;
      if (wsel == SEL_NONE) begin
        n.bresp = `RESP_ERR;
      end else if (wsel == SEL_STATUS) begin
        // Status is read only; the write is dropped.
      end else if (q.st != ST_IDLE) begin
        // Operands are frozen while an operation runs.
        n.bresp = `RESP_ERR;
      end else if (wsel == SEL_CMD) begin
        // The opcode sits in the low half and the extension word in the high half.
        {n.ext, n.op} = merge({q.ext, q.op}, q.wdata, q.wstrb);
        n.done = 1'b0;
        n.illegal = 1'b0;
        n.st = ST_EXEC;
      end else if (wsel == SEL_CCR) begin
        n.ccr = 5'(merge({27'h0, q.ccr}, q.wdata, q.wstrb));
      end else if (wsel == SEL_EA) begin
        n.ea = merge(q.ea, q.wdata, q.wstrb);
      end else begin
        n.dreg[q.awaddr[4:2]] = merge(q.dreg[q.awaddr[4:2]], q.wdata, q.wstrb);
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // Reads answer one cycle after the address is taken.
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OK;
      unique case (rsel)
        SEL_CMD: n.rdata = {q.ext, q.op};
        SEL_STATUS: n.rdata = {29'h0, q.st != ST_IDLE, q.illegal, q.done};
        SEL_CCR: n.rdata = {27'h0, q.ccr};
        SEL_EA: n.rdata = q.ea;
        SEL_DREG: n.rdata = q.dreg[s_axi_araddr[4:2]];
        default: begin
          n.rdata = 32'h0;
          n.rresp = `RESP_ERR;
        end
      endcase
    end
    n.arready = !n.rvalid;
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------

  // Synchronous reset clears all state.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign mem_req = q.mem_req;
  assign mem_we = q.mem_we;
  assign mem_addr = q.addr;
  assign mem_wdata = q.mem_wdata;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Steps of an operation.
  sequence s_exec_ok;
    q.st == ST_EXEC && legal;
  endsequence
  sequence s_rd_start;
    q.st == ST_READ && q.mem_req && !q.mem_we && q.cnt == 3'h0;
  endsequence
  sequence s_wr_last;
    q.st == ST_WRITE && mem_ack && q.cnt + 3'h1 == q.nbytes;
  endsequence

  // An illegal encoding leaves operands and flags alone.
  illegal_frozen_a: assert property (q.st == ST_EXEC && !legal |=>
    q.illegal && q.ccr == $past(q.ccr) && q.dreg == $past(q.dreg))
    else $error("illegal op changed state");
  // Clear on a register writes Z and keeps the other flags.
  clr_flags_a: assert property (s_exec_ok and clr && regdst |=>
    q.ccr[`CCR_Z] == !$past(tested) && q.ccr[4:3] == $past(q.ccr[4:3]) &&
    q.ccr[1:0] == $past(q.ccr[1:0]))
    else $error("bit clear flags wrong");
  // Clear on a register zeroes only the chosen bit.
  clr_reg_bit_a: assert property (s_exec_ok and clr && regdst |=>
    q.dreg[$past(rg)] == ($past(dsel) & ~(32'h1 << $past(bitnum[4:0]))))
    else $error("bit clear result wrong");
  // Field complement ends with V and C clear within 30 cycles.
  fld_vc_clear_a: assert property (s_exec_ok and fld |-> ##[1:30]
    (q.done && !q.ccr[`CCR_V] && !q.ccr[`CCR_C]))
    else $error("field flags not cleared");
  // Field complement on a register inverts the mask bits.
  fld_reg_inv_a: assert property (s_exec_ok and fld && regdst |=>
    q.dreg[$past(rg)] == ($past(dsel) ^ $past(rmask)))
    else $error("field not inverted");
  // Memory clear moves one byte only.
  clr_mem_byte_a: assert property (s_exec_ok and clr && !regdst |=>
    s_rd_start ##0 q.nbytes == 3'h1)
    else $error("memory clear not byte sized");
  // The written byte has its chosen bit low.
  clr_wr_bit_a: assert property (q.st == ST_WRITE && q.is_clr |->
    (q.mem_wdata & q.mask[39:32]) == 8'h00)
    else $error("memory bit not cleared");
  // Pointer register direct is refused.
  areg_refused_a: assert property (q.st == ST_EXEC && mode == `MODE_AREG |=>
    q.illegal && !q.mem_req)
    else $error("pointer mode accepted");
  // Field op refuses postincrement and predecrement.
  fld_mode_bad_a: assert property (q.st == ST_EXEC && fld &&
    (mode == `MODE_POSTINC || mode == `MODE_PREDEC) |=> q.illegal)
    else $error("field mode accepted");
  // The last write ends the operation.
  mem_end_a: assert property (s_wr_last |=> q.done && q.st == ST_IDLE && !q.mem_req)
    else $error("memory op did not end");
  // A write response holds until taken.
  b_hold_a: assert property (q.bvalid && !s_axi_bready |=> q.bvalid && $stable(q.bresp))
    else $error("write response dropped");

endmodule // bit_clear_field_complement_unit

/* File: shared/bit_unit_params.svh */
`ifndef BIT_UNIT_PARAMS_SVH
`define BIT_UNIT_PARAMS_SVH
// Register byte offsets on the AXI4-Lite slave.
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_CCR 8'h08
`define OFS_EA 8'h0c
`define OFS_DREG_HI 3'h1
// Condition code bit positions.
`define CCR_X 4
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0
// Bus responses.
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
// Opcode patterns.
`define OP_DYN_TOP 4'h0
`define OP_DYN_SEL 3'h6
`define OP_STAT 10'h022
`define OP_FLD 10'h3ab
// Addressing modes.
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`define MODE_EXT 3'h7
// Field width that a zero width code stands for.
`define FIELD_MAX 6'h20
`endif

/* File: shared/bit_unit_pkg.sv */
package bit_unit_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_READ, ST_WRITE} unit_state_t;
  // Register address classes.
  typedef enum logic [2:0] {SEL_NONE, SEL_CMD, SEL_STATUS, SEL_CCR, SEL_EA,
    SEL_DREG} reg_sel_t;
  // All state of the unit.
  typedef struct packed {
    unit_state_t st;
    logic [15:0] op;
    logic [15:0] ext;
    logic [7:0][31:0] dreg;
    logic [4:0] ccr;
    logic [31:0] ea;
    logic illegal;
    logic done;
    logic is_clr;
    logic [2:0] cnt;
    logic [2:0] nbytes;
    logic [31:0] addr;
    logic [39:0] bufv;
    logic [39:0] mask;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic mem_req;
    logic mem_we;
    logic [7:0] mem_wdata;
  } unit_regs_t;
endpackage
